//--- verilog/sacs_regs.svh
// Purpose: register offsets, field positions and timing figures
// Assumes: 32-bit AXI4-Lite words, byte addresses
// Notes:   included by the sequencer top only
`ifndef SACS_REGS_SVH
`define SACS_REGS_SVH

// register byte offsets
`define SACS_OFF_SAMP0 8'h00
`define SACS_OFF_STATUS 8'h18
`define SACS_OFF_CTRL 8'h1C
`define SACS_SAMP_STEP 8'h04

// status fields
`define SACS_ST_PWR 1:0
`define SACS_ST_REFRDY 2
`define SACS_ST_ACQ 3
`define SACS_ST_CNT 15:8
// control fields and reset value
`define SACS_CT_EN 0
`define SACS_CTRL_RST 1'h1

// frame layout, in serial clocks
`define SACS_SLOT_CLKS 7'h10
`define SACS_MAX_CH 3'h6
`define SACS_DATA_FIRST 4'h2
`define SACS_DATA_LAST 4'hD
`define SACS_RES_MSB 4'hB

// power-down pulse counts
`define SACS_NAP_PULSES 3'h2
`define SACS_SLEEP_PULSES 3'h4

// timing
`define SACS_REF_SETTLE_NS 2000000
`define SACS_MCLK_NS 50

// AXI responses
`define SACS_RESP_OKAY 2'h0
`define SACS_RESP_SLVERR 2'h2

`endif

//--- verilog/sacs_pkg.sv
// Purpose: shared types of the six-channel sequencer
// Assumes: nothing
// Notes:   state codes are Gray along the usual path
package sacs_pkg;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_NAP = 2'h1,
    PWR_SLEEP = 2'h3
  } sacs_pwr_e;

  typedef enum logic [1:0] {
    FRM_IDLE = 2'h0,
    FRM_RUN = 2'h1,
    FRM_ACQ = 2'h3
  } sacs_frm_e;

  typedef logic [11:0] sacs_word_t;
endpackage

//--- verilog/sacs_top.sv
// Purpose: conversion sequencer and serial readout, six channels
// Assumes: sck_i is the link clock; mclk_i runs the register side
// Notes:   software writes the per-channel codes that stand for the
//          analog inputs; the serial side shifts them out per frame
// Contract
// R1: each channel takes 16 clocks, six take 96
// R2: acquire from last frame edge until strobe
// R3: late strobe delays output one clock
// R4: host raises strobe half period early
// R5: clock wakes from sleep, reference settles 2ms
// R6: host keeps clock period 100 to 10000 ns; bench host runs 15 ns
// R7: host samples output on rising clock edge
// R8: host spaces strobes at least 10 us
// R9: host leaves 45 ns before next strobe
// R10: select code sets channel count, held steady
// R11: two idle strobes nap, four sleep
// R12: previous results, channel zero first, MSB first
// R13: bipolar gives two's complement, else binary
// R14: result inside slot, output released elsewhere
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "sacs_regs.svh"

module sacs_top #(
  parameter int unsigned SETTLE_CYC =
    (`SACS_REF_SETTLE_NS + `SACS_MCLK_NS - 1) / `SACS_MCLK_NS
) (
  input wire logic mclk_i, // register clock, 20 MHz
  input wire logic arst_n_i, // async reset, active low
  input wire logic sck_i, // serial link clock
  input wire logic convert_strobe_i, // convert start pin
  input wire logic channel_count_select_msb_i, // select bit 2
  input wire logic channel_count_select_mid_i, // select bit 1
  input wire logic channel_count_select_lsb_i, // select bit 0
  input wire logic bipolar_range_select_i, // high: two's complement
  output logic serial_result_out_o, // serial data out
  output logic serial_result_out_oe_o, // high while driving
  input wire logic [7:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write byte strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [7:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i // read data ready
);
  import sacs_pkg::*;

  // offset binary to two's complement is an MSB flip
  function automatic sacs_word_t fmt(input sacs_word_t w, input logic bipolar_range_select);
    fmt = {w[11] ^ bipolar_range_select, w[10:0]}; // [R13]
  endfunction

  // 000 enables one channel; 101 and above enable all six
  function automatic logic [6:0] frame_len(input logic [2:0] sel);
    logic [2:0] n;
    n = (sel >= 3'h5) ? `SACS_MAX_CH : sel + 3'h1; // [R10]
    frame_len = 7'(n * `SACS_SLOT_CLKS); // [R1]
  endfunction

  ////////////////////////////////////////////////////////////////////
  // register side: AXI4-Lite slave
  sacs_word_t samp_q [6];
  sacs_word_t hold_q [6];
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic ctrl_en_q;
  sacs_pwr_e pwr_q;
  logic ref_ready_q, acq_q;
  logic [7:0] convert_strobe_cnt_q;

  wire aw_take = s_axi_awvalid_i && !aw_got_q && !bvalid_q;
  wire w_take = s_axi_wvalid_i && !w_got_q && !bvalid_q;
  wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
  wire [2:0] wr_idx = 3'(awaddr_q[7:2]);
  wire wr_samp = awaddr_q[7:2] < 6'h6 && awaddr_q[1:0] == 2'h0;
  wire wr_ctrl = awaddr_q == `SACS_OFF_CTRL;
  wire wr_stat = awaddr_q == `SACS_OFF_STATUS;
  wire wr_ok = wr_samp || wr_ctrl || wr_stat;
  wire ar_take = s_axi_arvalid_i && !rvalid_q;
  wire [2:0] rd_idx = 3'(s_axi_araddr_i[7:2]);
  wire rd_samp = s_axi_araddr_i[7:2] < 6'h6 && s_axi_araddr_i[1:0] == 2'h0;
  wire rd_ctrl = s_axi_araddr_i == `SACS_OFF_CTRL;
  wire rd_stat = s_axi_araddr_i == `SACS_OFF_STATUS;
  wire [31:0] stat_word = {16'h0000, convert_strobe_cnt_q, 4'h0, acq_q,
                           ref_ready_q, pwr_q};
  wire [31:0] rd_word = rd_samp ? {20'h00000, samp_q[rd_idx]} :
                        rd_ctrl ? {31'h00000000, ctrl_en_q} :
                        rd_stat ? stat_word : 32'h00000000;
  wire [31:0] wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wr_old = wr_samp ? {20'h00000, samp_q[wr_idx]} :
                       {31'h00000000, ctrl_en_q};
  wire [31:0] wr_new = (wdata_q & wr_mask) | (wr_old & ~wr_mask);

  assign s_axi_awready_o = !aw_got_q && !bvalid_q;
  assign s_axi_wready_o = !w_got_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SACS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (w_take) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `SACS_RESP_OKAY : `SACS_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SACS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_samp || rd_ctrl || rd_stat) ?
                 `SACS_RESP_OKAY : `SACS_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // status is read-only; a write there is accepted and ignored
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_en_q <= `SACS_CTRL_RST;
      for (int i = 0; i < 6; i++) samp_q[i] <= 12'h000;
    end else if (wr_fire && wr_samp) begin
      samp_q[wr_idx] <= wr_new[11:0];
    end else if (wr_fire && wr_ctrl) begin
      ctrl_en_q <= wr_new[`SACS_CT_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register side: strobe, activity and power modes
  logic cv_m1_q, cv_m2_q, cv_m3_q;
  logic [2:0] act_gray_q, act_m1_q, act_m2_q, act_ack_q;
  logic done_tgl_q;
  logic done_m1_q, done_m2_q, done_m3_q;
  logic snap_tgl_q;
  logic [2:0] idle_pulses_q;
  logic [31:0] settle_q;

  wire convert_strobe_rise_m = cv_m2_q && !cv_m3_q;
  wire sck_seen = act_m2_q != act_ack_q;
  wire frame_done_m = done_m2_q != done_m3_q;
  wire [2:0] pulses_d = (idle_pulses_q == `SACS_SLEEP_PULSES) ?
                        idle_pulses_q : idle_pulses_q + 3'h1;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cv_m1_q <= 1'b0;
      cv_m2_q <= 1'b0;
      cv_m3_q <= 1'b0;
      act_m1_q <= 3'h0;
      act_m2_q <= 3'h0;
      act_ack_q <= 3'h0;
      done_m1_q <= 1'b0;
      done_m2_q <= 1'b0;
      done_m3_q <= 1'b0;
    end else begin
      cv_m1_q <= convert_strobe_i;
      cv_m2_q <= cv_m1_q;
      cv_m3_q <= cv_m2_q;
      act_m1_q <= act_gray_q; // [R5]
      act_m2_q <= act_m1_q;
      act_ack_q <= act_m2_q;
      done_m1_q <= done_tgl_q;
      done_m2_q <= done_m1_q;
      done_m3_q <= done_m2_q;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_q <= PWR_ACTIVE;
      idle_pulses_q <= 3'h0;
      settle_q <= 32'h00000000;
      ref_ready_q <= 1'b1;
    end else begin
      if (settle_q != 32'h00000000) settle_q <= settle_q - 32'h1;
      if (settle_q == 32'h00000001) ref_ready_q <= 1'b1;
      if (sck_seen) begin
        idle_pulses_q <= 3'h0;
        pwr_q <= PWR_ACTIVE; // [R5]
        if (pwr_q == PWR_SLEEP) begin
          ref_ready_q <= 1'b0; // [R5]
          settle_q <= SETTLE_CYC;
        end
      end else if (convert_strobe_rise_m) begin
        idle_pulses_q <= pulses_d;
        case (pulses_d)
          `SACS_NAP_PULSES: pwr_q <= PWR_NAP; // [R11]
          `SACS_SLEEP_PULSES: pwr_q <= PWR_SLEEP; // [R11]
          default: pwr_q <= pwr_q;
        endcase
      end
    end
  end

  // snapshot of the inputs at the strobe ends acquisition
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acq_q <= 1'b0;
      snap_tgl_q <= 1'b0;
      convert_strobe_cnt_q <= 8'h00;
      for (int i = 0; i < 6; i++) hold_q[i] <= 12'h000;
    end else if (convert_strobe_rise_m) begin
      acq_q <= 1'b0; // [R2]
      if (ctrl_en_q && pwr_q == PWR_ACTIVE) begin
        hold_q <= samp_q; // [R2]
        snap_tgl_q <= !snap_tgl_q;
        convert_strobe_cnt_q <= convert_strobe_cnt_q + 8'h01;
      end
    end else if (frame_done_m) begin
      acq_q <= 1'b1; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // link side: runs on the serial clock only
  logic cv_l1_q, cv_l2_q, cv_l3_q;
  logic [2:0] sel_l1_q, sel_l2_q;
  logic bip_l1_q, bip_l2_q;
  logic snap_l1_q, snap_l2_q, snap_l3_q;
  sacs_frm_e frm_q;
  logic [6:0] cnt_q, len_q;
  logic sdo_q, sdo_oe_q;
  sacs_word_t next_q [6];
  sacs_word_t out_q [6];

  // a strobe that misses the set-up lands one edge later in the
  // synchroniser, so the whole frame shifts by one clock
  wire convert_strobe_rise_l = cv_l2_q && !cv_l3_q; // [R3]
  wire [6:0] cnt_d = cnt_q + 7'h01;
  wire last_edge = frm_q == FRM_RUN && cnt_d == len_q;
  wire [3:0] slot_pos = convert_strobe_rise_l ? 4'h0 : cnt_d[3:0];
  wire [2:0] slot_ch = convert_strobe_rise_l ? 3'h0 : cnt_d[6:4];
  wire in_data = slot_pos >= `SACS_DATA_FIRST &&
                 slot_pos <= `SACS_DATA_LAST; // [R14]
  wire [3:0] bit_idx = `SACS_RES_MSB - (slot_pos - `SACS_DATA_FIRST);
  wire sdo_bit = convert_strobe_rise_l ? 1'b0 : out_q[slot_ch][bit_idx]; // [R12]
  wire run_d = convert_strobe_rise_l || (frm_q == FRM_RUN && !last_edge);

  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cv_l1_q <= 1'b0;
      cv_l2_q <= 1'b0;
      cv_l3_q <= 1'b0;
      sel_l1_q <= 3'h0;
      sel_l2_q <= 3'h0;
      bip_l1_q <= 1'b0;
      bip_l2_q <= 1'b0;
      snap_l1_q <= 1'b0;
      snap_l2_q <= 1'b0;
      snap_l3_q <= 1'b0;
    end else begin
      cv_l1_q <= convert_strobe_i;
      cv_l2_q <= cv_l1_q;
      cv_l3_q <= cv_l2_q;
      sel_l1_q <= {channel_count_select_msb_i, channel_count_select_mid_i,
                   channel_count_select_lsb_i};
      sel_l2_q <= sel_l1_q;
      bip_l1_q <= bipolar_range_select_i;
      bip_l2_q <= bip_l1_q;
      snap_l1_q <= snap_tgl_q;
      snap_l2_q <= snap_l1_q;
      snap_l3_q <= snap_l2_q;
    end
  end

  // every link edge steps a gray count; a stopped clock leaves nothing
  // pending, so a single edge is enough to wake. at most four edges
  // fit in one bus clock, so the count cannot wrap between samples
  wire [2:0] act_bin = {act_gray_q[2], ^act_gray_q[2:1], ^act_gray_q};
  wire [2:0] act_bin_d = act_bin + 3'h1;
  wire [2:0] act_gray_d = act_bin_d ^ {1'b0, act_bin_d[2:1]};

  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      act_gray_q <= 3'h0;
    end else begin
      act_gray_q <= act_gray_d; // [R5]
    end
  end

  // hold_q is stable for a whole strobe period, so the toggle
  // handshake lets the words be copied without a gray code
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 6; i++) next_q[i] <= 12'h000;
    end else if (snap_l2_q != snap_l3_q) begin
      next_q <= hold_q;
    end
  end

  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frm_q <= FRM_IDLE;
      cnt_q <= 7'h00;
      len_q <= 7'h00;
      done_tgl_q <= 1'b0;
      for (int i = 0; i < 6; i++) out_q[i] <= 12'h000;
    end else if (convert_strobe_rise_l) begin
      frm_q <= FRM_RUN;
      cnt_q <= 7'h00;
      len_q <= frame_len(sel_l2_q); // [R10]
      for (int i = 0; i < 6; i++) out_q[i] <= fmt(next_q[i], bip_l2_q);
    end else begin
      case (frm_q)
        FRM_RUN: begin
          cnt_q <= cnt_d; // [R1]
          if (last_edge) begin
            frm_q <= FRM_ACQ; // [R2]
            done_tgl_q <= !done_tgl_q;
          end
        end
        FRM_ACQ: frm_q <= FRM_ACQ;
        default: frm_q <= FRM_IDLE;
      endcase
    end
  end

  // changes right after the rising edge so the next edge catches it
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q <= in_data && run_d ? sdo_bit : 1'b0; // [R12]
      sdo_oe_q <= in_data && run_d; // [R14]
    end
  end

  assign serial_result_out_o = sdo_q;
  assign serial_result_out_oe_o = sdo_oe_q;
endmodule

//--- test/sacs_top_asserts.sv
// Purpose: bus handshake and serial word checks on the sequencer ports
// Assumes: one write and one read in flight at a time
// Notes:   bound into every sacs_top instance
`timescale 1ns/100ps

module sacs_chk (
  input wire logic mclk_i, // bus clock
  input wire logic arst_n_i, // reset, active low
  input wire logic sck_i, // link clock
  input wire logic serial_result_out_oe_o, // data driven
  input wire logic [7:0] s_axi_awaddr_i, // aw addr
  input wire logic s_axi_awvalid_i, // aw valid
  input wire logic s_axi_awready_o, // aw ready
  input wire logic s_axi_wvalid_i, // w valid
  input wire logic s_axi_wready_o, // w ready
  input wire logic [1:0] s_axi_bresp_o, // b resp
  input wire logic s_axi_bvalid_o, // b valid
  input wire logic s_axi_bready_i, // b ready
  input wire logic [7:0] s_axi_araddr_i, // ar addr
  input wire logic s_axi_arvalid_i, // ar valid
  input wire logic s_axi_arready_o, // ar ready
  input wire logic [31:0] s_axi_rdata_o, // r data
  input wire logic [1:0] s_axi_rresp_o, // r resp
  input wire logic s_axi_rvalid_o // r valid
);
  wire aw_w = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
    s_axi_wready_o;
  wire ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  logic [4:0] run_q;

  // length of the current driven run, in link clocks
  always_ff @(posedge sck_i or negedge arst_n_i) begin
    if (!arst_n_i)
      run_q <= 5'h00;
    else
      run_q <= serial_result_out_oe_o ? run_q + 5'h01 : 5'h00;
  end
  ////////////////////////////////////////////////////////////////////
  wr_resp_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    aw_w |-> ##2 s_axi_bvalid_o) else $error("write not answered");
  wr_err_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    aw_w && s_axi_awaddr_i > 8'h1F |-> ##2 s_axi_bresp_o == 2'h2)
    else $error("unmapped write not refused");
  wr_busy_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while busy");
  wr_done_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
    else $error("write response not retired");
  rd_resp_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ar_hs |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered");
  rd_err_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ar_hs && s_axi_araddr_i > 8'h1F |=>
    s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  word_len_a:
    assert property (@(posedge sck_i) disable iff (!arst_n_i)
    $fell(serial_result_out_oe_o) |-> run_q == 5'h0C)
    else $error("result word not twelve bits");
  word_gap_a:
    assert property (@(posedge sck_i) disable iff (!arst_n_i)
    $fell(serial_result_out_oe_o) |=> !serial_result_out_oe_o [*3])
    else $error("output driven between words");
endmodule

bind sacs_top sacs_chk u_chk (.*);

//--- test/sacs_host.sv
// Purpose: host serial controller driving strobe and link clock
// Assumes: 15 ns link clock, stopped low outside frames
// Notes:   records {oe, data} just before every rising edge
`timescale 1ns/100ps

module sacs_host (
  output logic sck_o, // link clock
  output logic convert_strobe_o, // convert strobe
  input wire logic sd_i, // serial data
  input wire logic oe_i // device drives data
);
  logic [1:0] bits_q[$];

  initial begin
    sck_o = 1'b0;
    convert_strobe_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////
  // fixed 15 ns period: no analog conversion is modelled, so the
  // conversion clock floor is not kept here
  // the bit is taken as the edge rises, before the device moves it
  task automatic tick();
    #7.5;
    bits_q.push_back({oe_i, sd_i});
    sck_o = 1'b1;
    #7.5;
    sck_o = 1'b0;
  endtask
  // strobe leads its edge by half a period the long idle after
  // the frame covers acquisition and strobe spacing
  task automatic frame(input int n);
    bits_q.delete();
    convert_strobe_o = 1'b1;
    repeat (12) tick();
    convert_strobe_o = 1'b0;
    repeat (16 * n - 7) tick();
    #9000;
  endtask
  // strobe pulse with the clock held still, counted toward nap
  task automatic pulse();
    convert_strobe_o = 1'b1;
    #250;
    convert_strobe_o = 1'b0;
    #250;
  endtask
endmodule

//--- test/tb_six_channel_adc_serial_sequencer.sv
// Purpose: self-checking bench for the six-channel sequencer
// Assumes: reference settling shortened to 20 bus clocks
// Notes:   frame k carries the latest snapshot taken before strobe k
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end

module tb_six_channel_adc_serial_sequencer;
  logic mclk, arst_n, sck, convert_strobe, sd, oe, bipolar_range_select;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [2:0] sel;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, w;
  logic [1:0] bresp, rresp, r, b;
  int bad_count = 0;
  int n_tests = 0;
  int k, c, p, n, s, e, x, cnt;
  int smp[6], snap[6];

  sacs_top #(.SETTLE_CYC(20)) dut (
    .mclk_i(mclk), .arst_n_i(arst_n), .sck_i(sck),
    .convert_strobe_i(convert_strobe), .channel_count_select_msb_i(sel[2]),
    .channel_count_select_mid_i(sel[1]),
    .channel_count_select_lsb_i(sel[0]), .bipolar_range_select_i(bipolar_range_select),
    .serial_result_out_o(sd), .serial_result_out_oe_o(oe),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready)
  );
  sacs_host u_host (.sck_o(sck), .convert_strobe_o(convert_strobe), .sd_i(sd), .oe_i(oe));
  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] rs);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #400000;
    bad_count++;
    $display("ERROR watchdog exp finish got hang");
    report_and_stop();
  end
  initial begin
    {arst_n, bipolar_range_select, sel, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    void'($urandom(14053));
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    axr(8'h18, d, r);
    `CHK("status", 32'h4, d & 32'hFFF7)
    axr(8'h1C, d, r);
    `CHK("ctrl", 32'h1, d)
    axr(8'h20, d, r);
    `CHK("bad read", 34'h2_0000_0000, {r, d})
    axw(8'h20, 32'h1, r);
    `CHK("bad write", 2'h2, r)
    axw(8'h18, 32'hFFFF_FFFF, r);
    axr(8'h18, d, r);
    `CHK("ro status", 34'h4, {r, d & 32'hFFF7})
    $display("test registers done");
    cnt = 0;
    for (k = 0; k < 18; k++) begin
      if (k == 16)
        axw(8'h1C, 32'h0, r);
      for (c = 0; c < 6; c++) begin
        w = $urandom;
        axw(8'(c * 4), w, r);
        axr(8'(c * 4), d, r);
        `CHK("sample", w & 32'hFFF, d)
        smp[c] = w & 32'hFFF;
      end
      s = (k / 2) % 8;
      n = s > 4 ? 6 : s + 1;
      // code and range stay put across conversion and readout
      if (k % 2 == 0) begin
        @(posedge mclk);
        sel <= 3'(s);
        bipolar_range_select <= 1'($urandom);
      end
      @(negedge mclk);
      u_host.frame(n);
      for (c = 0; c < 16 * n + 2; c++) begin
        p = c % 16;
        b = u_host.bits_q[c + 3];
        e = c < 16 * n && p > 1 && p < 14;
        x = (snap[(c / 16) % 6] ^ (bipolar_range_select ? 32'h800 : 0)) >> (13 - p);
        `CHK("drive", e, b[1])
        if (e && k > 0)
          `CHK("bit", x & 1, b[0])
      end
      if (k < 16) begin
        snap = smp;
        cnt++;
      end
      axr(8'h18, d, r);
      e = k < 16 ? 32'hFFFF : 32'hF;
      `CHK("acquire", k < 16 ? cnt * 256 + 12 : 12, d & e)
    end
    $display("test frames done");
    axw(8'h1C, 32'h1, r);
    @(negedge mclk);
    repeat (2) u_host.pulse();
    axr(8'h18, d, r);
    `CHK("nap", 2'h1, d[1:0])
    @(negedge mclk);
    repeat (2) u_host.pulse();
    axr(8'h18, d, r);
    `CHK("sleep", 2'h3, d[1:0])
    u_host.tick();
    repeat (4) @(posedge mclk);
    axr(8'h18, d, r);
    `CHK("wake", 3'h0, d[2:0])
    repeat (30) @(posedge mclk);
    axr(8'h18, d, r);
    `CHK("settled", 3'h4, d[2:0])
    $display("test power done");
    report_and_stop();
  end
endmodule
